// ==== hw/psl_pkg.sv ====
// Package of constants for the strap latch block
package psl_pkg;
   localparam int ADDR_W = 5;
   localparam logic [4:0] ADDR_UNSTRAPPED = 5'h01;
   localparam logic [4:0] ISOLATE_ADDR = 5'h00;
   // Register map offsets
   localparam logic [3:0] REG_PHY_CONTROL_REG = 4'h0;
   localparam logic [3:0] REG_BMCR = 4'h1;
   localparam logic [3:0] REG_ANAR = 4'h2;
   localparam logic [3:0] REG_STRAP = 4'h3;
   // Basic mode control fields
   localparam int BMCR_ANEN_BIT = 12;
   localparam int BMCR_SPEED_BIT = 13;
   localparam int BMCR_DUPLEX_BIT = 8;
   localparam int BMCR_ISOLATE_BIT = 10;
   localparam logic [15:0] BMCR_RESET = 16'h0000;
   // Advertisement fields
   localparam int ANAR_10HD_BIT = 5;
   localparam int ANAR_10FD_BIT = 6;
   localparam int ANAR_100HD_BIT = 7;
   localparam int ANAR_100FD_BIT = 8;
   localparam logic [15:0] ANAR_SELECTOR = 16'h0001;
   localparam logic [15:0] PHY_CONTROL_REG_RESET = 16'h0000;
   // Strap capture delay after reset release, in cycles
   localparam logic [1:0] CAPTURE_CYCLES = 2'h3;
endpackage

// ==== hw/psl_sync.sv ====
// Two-stage synchroniser for strap pins
`timescale 1ns/10ps
`default_nettype none
module psl_sync #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         dout <= '0;
      end else if (ce) begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== hw/psl_strap_latch.sv ====
// Strap latch: captures straps after reset into initial PHY configuration
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module psl_strap_latch (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [4:0] strap_mgmt_address,
   input wire logic autoneg_enable_strap,
   input wire logic mode_select_strap_hi,
   input wire logic mode_select_strap_lo,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic [4:0] mgmt_address,
   output logic isolate,
   output logic autoneg_enable,
   output logic speed_100,
   output logic full_duplex,
   output logic [15:0] advert,
   output logic config_valid
);
   logic [7:0] pins_sync;
   logic [1:0] cap_cnt;
   logic captured;
   logic [15:0] phy_control_reg;
   logic [15:0] bmcr;
   logic [15:0] anar;
   logic [2:0] an_strap;
   wire logic [4:0] addr_pin = pins_sync[4:0];
   wire logic autoneg_enable_strap_pin = pins_sync[7];
   wire logic [1:0] mode_pin = pins_sync[6:5];
   wire logic capture_now = ce && !captured &&
      (cap_cnt == psl_pkg::CAPTURE_CYCLES);
   wire logic wr_phy_control_reg = reg_wr && (reg_addr == psl_pkg::REG_PHY_CONTROL_REG);
   wire logic wr_bmcr = reg_wr && (reg_addr == psl_pkg::REG_BMCR);
   wire logic wr_anar = reg_wr && (reg_addr == psl_pkg::REG_ANAR);
   // Forced mode decode: hi bit selects 100, lo bit full duplex
   wire logic f_speed = mode_pin[1];
   wire logic f_duplex = mode_pin[0];
   logic [15:0] next_anar;
   logic [15:0] next_bmcr;
   logic [15:0] rd_mux;

   psl_sync #(.WIDTH(8)) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .din({autoneg_enable_strap, mode_select_strap_hi,
            mode_select_strap_lo, strap_mgmt_address}),
      .dout(pins_sync)
   );

   // Advertised capability from the mode-select pair
   always_comb begin
      next_anar = psl_pkg::ANAR_SELECTOR;
      case (mode_pin)
         2'h0: begin
            next_anar[psl_pkg::ANAR_10HD_BIT] = 1'b1;
            next_anar[psl_pkg::ANAR_10FD_BIT] = 1'b1;
         end
         2'h1: begin
            next_anar[psl_pkg::ANAR_100HD_BIT] = 1'b1;
            next_anar[psl_pkg::ANAR_100FD_BIT] = 1'b1;
         end
         2'h2: begin
            next_anar[psl_pkg::ANAR_10HD_BIT] = 1'b1;
            next_anar[psl_pkg::ANAR_100HD_BIT] = 1'b1;
         end
         default: begin
            next_anar[psl_pkg::ANAR_10HD_BIT] = 1'b1;
            next_anar[psl_pkg::ANAR_10FD_BIT] = 1'b1;
            next_anar[psl_pkg::ANAR_100HD_BIT] = 1'b1;
            next_anar[psl_pkg::ANAR_100FD_BIT] = 1'b1;
         end
      endcase
   end

   always_comb begin
      next_bmcr = psl_pkg::BMCR_RESET;
      next_bmcr[psl_pkg::BMCR_ANEN_BIT] = autoneg_enable_strap_pin;
      // Forced speed and duplex only when negotiation is off
      next_bmcr[psl_pkg::BMCR_SPEED_BIT] = !autoneg_enable_strap_pin && f_speed;
      next_bmcr[psl_pkg::BMCR_DUPLEX_BIT] = !autoneg_enable_strap_pin && f_duplex;
      next_bmcr[psl_pkg::BMCR_ISOLATE_BIT] =
         (addr_pin == psl_pkg::ISOLATE_ADDR);
   end

   always_comb begin
      case (reg_addr)
         psl_pkg::REG_PHY_CONTROL_REG: rd_mux = phy_control_reg;
         psl_pkg::REG_BMCR: rd_mux = bmcr;
         psl_pkg::REG_ANAR: rd_mux = anar;
         psl_pkg::REG_STRAP: rd_mux = {12'h000, captured, an_strap};
         default: rd_mux = 16'h0000;
      endcase
   end

   // Capture delay lets the synchroniser settle after release
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cap_cnt <= 2'h0;
         captured <= 1'b0;
      end else if (ce && !captured) begin
         if (capture_now) begin
            captured <= 1'b1;
         end else begin
            cap_cnt <= cap_cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         phy_control_reg <= psl_pkg::PHY_CONTROL_REG_RESET;
      end else if (capture_now) begin
         phy_control_reg <= {11'h000, addr_pin};
      end else if (ce && captured && wr_phy_control_reg) begin
         phy_control_reg <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bmcr <= psl_pkg::BMCR_RESET;
         anar <= psl_pkg::ANAR_SELECTOR;
         an_strap <= 3'h0;
      end else if (capture_now) begin
         bmcr <= next_bmcr;
         anar <= next_anar;
         an_strap <= {autoneg_enable_strap_pin, mode_pin};
      end else if (ce && captured) begin
         if (wr_bmcr) begin
            bmcr <= reg_wdata;
         end
         if (wr_anar) begin
            anar <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // Isolate follows bmcr only; address writes never set it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mgmt_address <= 5'h00;
         isolate <= 1'b0;
         autoneg_enable <= 1'b0;
         speed_100 <= 1'b0;
         full_duplex <= 1'b0;
         advert <= 16'h0000;
         config_valid <= 1'b0;
      end else if (ce) begin
         mgmt_address <= phy_control_reg[4:0];
         isolate <= bmcr[psl_pkg::BMCR_ISOLATE_BIT];
         autoneg_enable <= bmcr[psl_pkg::BMCR_ANEN_BIT];
         speed_100 <= bmcr[psl_pkg::BMCR_SPEED_BIT];
         full_duplex <= bmcr[psl_pkg::BMCR_DUPLEX_BIT];
         advert <= anar;
         config_valid <= captured;
      end
   end
endmodule
`default_nettype wire

// ==== test/psl_strap_monitor.sv ====
// Checker of the strap latch outputs
`timescale 1ns/10ps
`default_nettype none
module psl_strap_monitor (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic [4:0] mgmt_address,
   input wire logic isolate,
   input wire logic autoneg_enable,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic [15:0] advert,
   input wire logic config_valid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   iso_strap_a: assert property (
      $rose(isolate) |-> mgmt_address == 5'h00) else $error("isolate bad");
   iso_late_a: assert property (
      $rose(isolate) |-> !$past(config_valid)) else $error("isolate late");
   forced_off_a: assert property (
      autoneg_enable |-> !speed_100 && !full_duplex) else $error("forced set");
   adv_sel_a: assert property (
      config_valid && autoneg_enable |-> advert[4:0] == 5'h01)
      else $error("selector bad");
   adv_some_a: assert property (
      config_valid && autoneg_enable |-> advert[8:5] != 4'h0)
      else $error("no ability");
   valid_hold_a: assert property (
      config_valid |=> config_valid) else $error("valid dropped");
   mode_hold_a: assert property (
      config_valid && $past(config_valid) |-> $stable(advert))
      else $error("advert moved");
   addr_hold_a: assert property (
      config_valid && $past(config_valid) && !$past(reg_wr)
      && !$past(reg_wr, 2) |-> $stable(mgmt_address)) else $error("addr moved");
   cover property ($rose(isolate));
   cover property ($rose(config_valid) && autoneg_enable);
   cover property (config_valid && reg_wr);
endmodule
`default_nettype wire

// ==== test/psl_strap_board.sv ====
// Board strap resistors model
`timescale 1ns/10ps
`default_nettype none
module psl_strap_board (
   input wire logic float_addr,
   input wire logic [7:0] setting,
   output logic [4:0] addr_pin,
   output logic [2:0] mode_pin
);
   // Unfitted address resistors leave the internal pulls
   assign addr_pin = float_addr ? 5'h01 : setting[7:3];
   assign mode_pin = setting[2:0];
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Testbench of the strap latch
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic core_clk = 1'b0, nrst = 1'b0, ce = 1'b1, fl = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, isolate, autoneg_enable;
   logic speed_100, full_duplex, config_valid;
   logic [7:0] set = 8'h00;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, advert;
   logic [4:0] strap_mgmt_address, mgmt_address, a;
   logic [2:0] m;
   logic [15:0] adv_t [4] = '{16'h0061, 16'h0181, 16'h00A1, 16'h01E1};
   logic [8:0] rows [8] = '{9'h000, 9'h0F9, 9'h0AA, 9'h053,
      9'h014, 9'h025, 9'h0C6, 9'h107};
   int n_mismatch = 0, samples_checked = 0, cyc = 0;
   psl_strap_board brd (.float_addr(fl), .setting(set),
      .addr_pin(strap_mgmt_address), .mode_pin(m));
   psl_strap_latch dut (.core_clk, .nrst, .ce, .strap_mgmt_address,
      .autoneg_enable_strap(m[2]), .mode_select_strap_hi(m[1]),
      .mode_select_strap_lo(m[0]), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .mgmt_address, .isolate, .autoneg_enable, .speed_100,
      .full_duplex, .advert, .config_valid);
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic boot(input logic [8:0] r);
      @(posedge core_clk);
      nrst <= 1'b0;
      fl <= r[8];
      set <= r[7:0];
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (8) @(posedge core_clk);
      #1;
   endtask
   task automatic bus(input logic w, input logic [3:0] ad, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      if (!w) chk("read data", d, reg_rdata);
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      foreach (rows[i]) begin
         boot(rows[i]);
         a = strap_mgmt_address;
         chk("address", {11'h000, rows[i][8] ? 5'h01 : rows[i][7:3]},
            {11'h000, mgmt_address});
         chk("isolate", {15'h0000, a == 5'h00}, {15'h0000, isolate});
         chk("autoneg", {15'h0000, m[2]}, {15'h0000, autoneg_enable});
         chk("speed", {15'h0000, !m[2] & m[1]}, {15'h0000, speed_100});
         chk("duplex", {15'h0000, !m[2] & m[0]}, {15'h0000, full_duplex});
         if (m[2]) chk("advert", adv_t[m[1:0]], advert);
         chk("valid", 16'h0001, {15'h0000, config_valid});
         $display("row %0d done", i);
      end
      set <= 8'h00;
      fl <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      chk("held address", 16'h0001, {11'h000, mgmt_address});
      chk("held autoneg", 16'h0001, {15'h0000, autoneg_enable});
      chk("held advert", 16'h01E1, advert);
      bus(1'b0, 4'h1, 16'h1000);
      bus(1'b0, 4'h2, 16'h01E1);
      bus(1'b0, 4'hF, 16'h0000);
      $display("strap hold test done");
      boot(9'h01C);
      bus(1'b1, 4'h0, 16'h0000);
      repeat (3) @(posedge core_clk);
      #1;
      chk("written address", 16'h0000, {11'h000, mgmt_address});
      chk("written isolate", 16'h0000, {15'h0000, isolate});
      $display("address write test done");
      @(posedge core_clk);
      ce <= 1'b0;
      bus(1'b1, 4'h0, 16'h0005);
      repeat (3) @(posedge core_clk);
      #1;
      chk("frozen address", 16'h0000, {11'h000, mgmt_address});
      chk("frozen valid", 16'h0001, {15'h0000, config_valid});
      @(posedge core_clk);
      ce <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk("dropped write", 16'h0000, {11'h000, mgmt_address});
      $display("clock enable test done");
      complete_run();
   end
endmodule
bind psl_strap_latch psl_strap_monitor mon (.core_clk, .nrst, .reg_wr,
   .mgmt_address, .isolate, .autoneg_enable, .speed_100, .full_duplex,
   .advert, .config_valid);
`default_nettype wire
